// >>> atr_pkg.sv
package atr_pkg;
  // utility bus register map
  localparam logic [7:0] OFF_MASTER = 8'h00;
  localparam logic [7:0] OFF_FLAGS = 8'h01;
  localparam logic [7:0] OFF_DIAG = 8'h02;
  localparam logic [7:0] MASTER_RST = 8'h09;
  localparam logic [7:0] DIAG_RST = 8'h00;
  localparam logic [5:0] STICKY_RST = 6'h00;
  // master control fields
  localparam int MC_UOL = 7;
  localparam int MC_ERR_DISC = 6;
  localparam int MC_ERR_ONLY = 5;
  localparam int MC_TXPAR = 4;
  localparam int MC_IDLE_DISC = 3;
  localparam int MC_HALT = 2;
  localparam int MC_BYTE = 1;
  localparam int MC_INT_EN = 0;
  // interrupt flag fields
  localparam int IF_GOOD = 6;
  localparam int IF_HEC = 5;
  localparam int IF_SHORT = 4;
  localparam int IF_PAR = 3;
  localparam int IF_CHG = 2;
  localparam int IF_SYM = 1;
  localparam int IF_OVR = 0;
  // diagnostic control fields
  localparam int DC_FORCE = 7;
  localparam int DC_EARLY = 6;
  localparam int DC_MULTI = 5;
  localparam int DC_FLUSH = 4;
  localparam int DC_PAY_ERR = 3;
  localparam int DC_HEC_ERR = 2;
  // control levels carried into the link domain
  localparam int CT_ERR_DISC = 0;
  localparam int CT_IDLE_DISC = 1;
  localparam int CT_TXPAR = 2;
  localparam int CT_HALT = 3;
  localparam int CT_BYTE = 4;
  localparam int CT_FORCE = 5;
  localparam int CT_EARLY = 6;
  localparam int CT_MULTI = 7;
  localparam int CT_PAY_ERR = 8;
  localparam int CT_HEC_ERR = 9;
  localparam int CT_FLUSH = 10;
  localparam int CT_W = 11;
  // event toggles carried back from the link domain
  localparam int EV_HEC = 0;
  localparam int EV_SHORT = 1;
  localparam int EV_SYM = 2;
  localparam int EV_OVR = 3;
  localparam int EV_PAR = 4;
  localparam int EV_N = 5;
  // cell length and early clav byte count; HEC and last byte positions counted from zero
  localparam logic [5:0] CELL_BYTES = 6'd53;
  localparam logic [5:0] HEC_POS = 6'd4;
  localparam logic [5:0] LAST_POS = 6'd52;
  localparam logic [5:0] EARLY_CNT = 6'd49;

  typedef enum logic [1:0] {LOOP_NORMAL, LOOP_PHY, LOOP_LINE} atr_loop_e;

  // reserved code 01 behaves as normal
  function automatic atr_loop_e atr_loop_decode(input logic [1:0] f);
    unique case (f)
      2'b10: atr_loop_decode = LOOP_PHY;
      2'b11: atr_loop_decode = LOOP_LINE;
      default: atr_loop_decode = LOOP_NORMAL;
    endcase
  endfunction
endpackage

// >>> atr_link.sv
`timescale 1ns/1ps
module atr_link import atr_pkg::*; (
  input wire logic link_clk_i,
  input wire logic resetn_i,
  input wire logic [CT_W-1:0] ctrl_i,
  output logic [EV_N-1:0] ev_tgl_o,
  output logic flush_ack_o,
  input wire logic rx_cell_done_i,
  input wire logic rx_cell_short_i,
  input wire logic rx_cell_sym_err_i,
  input wire logic rx_cell_hec_err_i,
  input wire logic rx_cell_idle_i,
  input wire logic rx_overrun_i,
  output logic rx_cell_drop_o,
  output logic rx_fifo_flush_o,
  input wire logic tx_byte_valid_i,
  input wire logic tx_soc_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_parity_i,
  input wire logic tx_clav_raw_i,
  input wire logic txd_p_raw_i,
  input wire logic txd_n_raw_i,
  output logic [7:0] tx_line_data_o,
  output logic tx_line_valid_o,
  output logic tx_clav_o,
  output logic txd_p_o,
  output logic txd_n_o,
  input wire logic rx_enb_n_i,
  input wire logic [1:0] rx_cells_queued_i,
  input wire logic rx_byte_avail_i,
  input wire logic [7:0] rx_fifo_data_i,
  input wire logic rx_fifo_parity_i,
  input wire logic rx_fifo_soc_i,
  output logic [7:0] rx_data_o,
  output logic receive_parity_out_o,
  output logic rx_soc_o,
  output logic rx_out_oe_o,
  output logic rx_clav_o,
  output logic rx_fifo_pop_o
);
  logic [CT_W-1:0] ct_s1_q, ct_s2_q;
  logic [EV_N-1:0] ev_q, ev_d;
  logic ack_q;
  logic [5:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d, tx_pos;
  logic [7:0] txb_q, txb_d, rxb_q, rxb_d;
  logic txv_q, txv_d, rxp_q, rxp_d, rxs_q, rxs_d, txdp_q, txdp_d;
  logic txdn_q, txdn_d;
  logic bad_cell;

  // control levels from the register side pass two flops
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ct_s1_q <= '0;
      ct_s2_q <= '0;
    end else begin
      ct_s1_q <= ctrl_i;
      ct_s2_q <= ct_s1_q;
    end
  end

  assign tx_pos = tx_soc_i ? 6'd0 : tx_cnt_q;
  assign bad_cell = rx_cell_short_i | rx_cell_sym_err_i | rx_cell_hec_err_i;
  // drop decision is given with the cell end strobe
  assign rx_cell_drop_o = rx_cell_done_i &                  // see R2, R6
    ((ct_s2_q[CT_ERR_DISC] & bad_cell) |
     (ct_s2_q[CT_IDLE_DISC] & rx_cell_idle_i));
  assign tx_clav_o = tx_clav_raw_i & ~ct_s2_q[CT_FORCE];   // see R17
  assign rx_out_oe_o = ~(ct_s2_q[CT_MULTI] & rx_enb_n_i);   // see R19
  assign rx_fifo_pop_o = ~rx_enb_n_i & rx_byte_avail_i;
  assign rx_fifo_flush_o = ct_s2_q[CT_FLUSH] & ~ack_q;      // see R20
  assign flush_ack_o = ack_q;
  // cell mode may drop clav once byte 49 (payload 44) has gone
  always_comb begin
    if (ct_s2_q[CT_BYTE]) begin
      rx_clav_o = rx_byte_avail_i;                          // see R8
    end else if (ct_s2_q[CT_EARLY]) begin
      rx_clav_o = (rx_cells_queued_i > 2'd1) ||             // see R18
        (rx_cells_queued_i == 2'd1 && rx_cnt_q < EARLY_CNT);
    end else begin
      rx_clav_o = rx_cells_queued_i != 2'd0;
    end
  end

  // next values: events, byte counters, error insertion, halt
  always_comb begin
    ev_d = ev_q;
    if (rx_cell_done_i && rx_cell_hec_err_i) ev_d[EV_HEC] = ~ev_q[EV_HEC];
    if (rx_cell_done_i && rx_cell_short_i) ev_d[EV_SHORT] = ~ev_q[EV_SHORT];
    if (rx_cell_done_i && rx_cell_sym_err_i) ev_d[EV_SYM] = ~ev_q[EV_SYM];
    if (rx_overrun_i) ev_d[EV_OVR] = ~ev_q[EV_OVR];
    if (ct_s2_q[CT_TXPAR] && tx_byte_valid_i &&              // see R4
        !(^{tx_data_i, tx_parity_i})) begin
      ev_d[EV_PAR] = ~ev_q[EV_PAR];                         // see R5
    end
    tx_cnt_d = tx_cnt_q;
    if (tx_byte_valid_i) tx_cnt_d = tx_pos + 6'd1;
    txb_d = tx_data_i;
    txb_d[0] = tx_data_i[0] ^
      ((ct_s2_q[CT_PAY_ERR] && tx_pos == LAST_POS) ||       // see R21
       (ct_s2_q[CT_HEC_ERR] && tx_pos == HEC_POS));         // see R22
    txv_d = tx_byte_valid_i & ~ct_s2_q[CT_HALT];             // see R7
    txdp_d = txd_p_raw_i & ~ct_s2_q[CT_HALT];
    txdn_d = txd_n_raw_i & ~ct_s2_q[CT_HALT];
    rx_cnt_d = rx_cnt_q;
    rxb_d = rxb_q;
    rxp_d = rxp_q;
    rxs_d = rxs_q;
    if (rx_fifo_pop_o) begin
      rx_cnt_d = rx_fifo_soc_i ? 6'd1 : rx_cnt_q + 6'd1;
      if (rx_cnt_d == CELL_BYTES) rx_cnt_d = 6'd0;
      rxb_d = rx_fifo_data_i;
      rxp_d = rx_fifo_parity_i;
      rxs_d = rx_fifo_soc_i;
    end
  end

  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ev_q <= '0;
      ack_q <= 1'b0;
      tx_cnt_q <= 6'd0;
      rx_cnt_q <= 6'd0;
      txb_q <= 8'h00;
      txv_q <= 1'b0;
      txdp_q <= 1'b0;
      txdn_q <= 1'b0;
      rxb_q <= 8'h00;
      rxp_q <= 1'b0;
      rxs_q <= 1'b0;
    end else begin
      ev_q <= ev_d;
      ack_q <= ct_s2_q[CT_FLUSH];
      tx_cnt_q <= tx_cnt_d;
      rx_cnt_q <= rx_cnt_d;
      txb_q <= txb_d;
      txv_q <= txv_d;
      txdp_q <= txdp_d;
      txdn_q <= txdn_d;
      rxb_q <= rxb_d;
      rxp_q <= rxp_d;
      rxs_q <= rxs_d;
    end
  end

  assign ev_tgl_o = ev_q;
  assign tx_line_data_o = txb_q;
  assign tx_line_valid_o = txv_q;
  assign txd_p_o = txdp_q;
  assign txd_n_o = txdn_q;
  assign rx_data_o = rxb_q;
  assign receive_parity_out_o = rxp_q;
  assign rx_soc_o = rxs_q;
endmodule

// >>> atr_regs.sv
// Operation
// R1: user pin drives inverse of latch bit
// R2: error cells dropped when discard enabled
// R3: cell-error-only mode limits interrupt sources
// R4: transmit parity checked when enabled
// R5: odd parity failure sets sticky flag
// R6: idle cells silently dropped by default
// R7: transmit halt stops data, line low
// R8: mode bit selects cell or byte
// R9: interrupt pin disabled stays high
// R10: signal quality readable, 1 is good
// R11: HEC error sets sticky flag
// R12: short cell sets sticky flag
// R13: signal change sets sticky flag
// R14: undefined symbol sets sticky flag
// R15: receive FIFO overflow sets sticky flag
// R16: reading flag register clears sticky flags
// R17: force bit holds transmit clav inactive
// R18: early mode drops rx clav after payload 44
// R19: multi-PHY tri-states outputs when not enabled
// R20: flush empties FIFO then clears bit
// R21: payload error flips last payload bit 0
// R22: HEC error flips header check bit 0
// R23: loopback field decodes normal, PHY, line
// R24: PHY loopback loops transmit to receive
// R25: interrupt held while qualifying flags set
// R26: reserved loopback code acts as normal
`timescale 1ns/1ps
module atr_regs import atr_pkg::*; (
  input wire logic core_clk_i,
  input wire logic link_clk_i,
  input wire logic resetn_i,
  input wire logic ub_cs_n_i,
  input wire logic ub_ale_i,
  input wire logic ub_rd_n_i,
  input wire logic ub_wr_n_i,
  input wire logic [7:0] ub_ad_i,
  output logic [7:0] ub_ad_o,
  output logic ub_ad_oe_o,
  input wire logic rx_signal_good_i,
  output logic user_out_pin_o,
  output logic int_n_o,
  output logic utopia_byte_mode_o,
  output logic phy_loopback_o,
  output logic line_loopback_o,
  input wire logic rx_cell_done_i,
  input wire logic rx_cell_short_i,
  input wire logic rx_cell_sym_err_i,
  input wire logic rx_cell_hec_err_i,
  input wire logic rx_cell_idle_i,
  input wire logic rx_overrun_i,
  output logic rx_cell_drop_o,
  output logic rx_fifo_flush_o,
  input wire logic tx_byte_valid_i,
  input wire logic tx_soc_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_parity_i,
  input wire logic tx_clav_raw_i,
  input wire logic txd_p_raw_i,
  input wire logic txd_n_raw_i,
  output logic [7:0] tx_line_data_o,
  output logic tx_line_valid_o,
  output logic tx_clav_o,
  output logic txd_p_o,
  output logic txd_n_o,
  input wire logic rx_enb_n_i,
  input wire logic [1:0] rx_cells_queued_i,
  input wire logic rx_byte_avail_i,
  input wire logic [7:0] rx_fifo_data_i,
  input wire logic rx_fifo_parity_i,
  input wire logic rx_fifo_soc_i,
  output logic [7:0] rx_data_o,
  output logic receive_parity_out_o,
  output logic rx_soc_o,
  output logic rx_out_oe_o,
  output logic rx_clav_o,
  output logic rx_fifo_pop_o
);
  typedef enum logic [1:0] {FL_IDLE, FL_REQ, FL_DONE} atr_flush_e;

  // pin synchronisers: {cs_n, ale, rd_n, wr_n, good}
  logic [4:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic [7:0] ad_s1_q, ad_s2_q;
  logic [EV_N-1:0] ev_s1_q, ev_s2_q, ev_s3_q, ev_pulse;
  logic ack_s1_q, ack_s2_q;
  logic cs_act, ale_fall, rd_start, rd_stop, wr_stop;
  logic [7:0] addr_q, addr_d, wdata_q, wdata_d, rdata_q, rdata_d;
  logic rd_act_q, rd_act_d, wr_commit;
  logic [7:0] mc_q, mc_d, dc_q, dc_d;
  logic [5:0] sticky_q, sticky_d, sticky_set, sticky_clr;
  atr_flush_e fl_q, fl_d;
  logic flreq_q, flreq_d, flush_done;
  logic int_q, int_d, err_any, pend;
  logic uol_q, uol_d, bym_q, bym_d, phyl_q, phyl_d, linl_q, linl_d;
  logic [CT_W-1:0] ctrl_q, ctrl_d;
  logic flush_ack;
  logic [EV_N-1:0] ev_tgl;
  atr_loop_e loop_mode;

  // every pin and link-domain signal passes two flops first
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s1_q <= 5'h16;
      pin_s2_q <= 5'h16;
      pin_s3_q <= 5'h16;
      ad_s1_q <= 8'h00;
      ad_s2_q <= 8'h00;
      ev_s1_q <= '0;
      ev_s2_q <= '0;
      ev_s3_q <= '0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= {ub_cs_n_i, ub_ale_i, ub_rd_n_i, ub_wr_n_i,
                   rx_signal_good_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      ad_s1_q <= ub_ad_i;
      ad_s2_q <= ad_s1_q;
      ev_s1_q <= ev_tgl;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
      ack_s1_q <= flush_ack;
      ack_s2_q <= ack_s1_q;
    end
  end

  // strobe edges seen after synchronisation
  assign cs_act = ~pin_s2_q[4];
  assign ale_fall = pin_s3_q[3] & ~pin_s2_q[3];
  assign rd_start = cs_act & pin_s3_q[2] & ~pin_s2_q[2];
  assign rd_stop = rd_act_q & pin_s2_q[2];
  assign wr_stop = cs_act & ~pin_s3_q[1] & pin_s2_q[1];
  assign wr_commit = wr_stop;
  assign ev_pulse = ev_s2_q ^ ev_s3_q;

  // bus side: address latch, write data, read data
  always_comb begin
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    rd_act_d = rd_act_q;
    if (ale_fall) addr_d = ad_s2_q;
    if (cs_act && !pin_s2_q[1]) wdata_d = ad_s2_q;
    if (rd_start) begin
      rd_act_d = 1'b1;
      unique case (addr_q)
        OFF_MASTER: rdata_d = mc_q;
        OFF_FLAGS: rdata_d = {1'b0, pin_s3_q[0], sticky_q};  // see R10
        OFF_DIAG: rdata_d = dc_q;
        default: rdata_d = 8'h00;
      endcase
    end else if (rd_stop) begin
      rd_act_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      rd_act_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      rd_act_q <= rd_act_d;
    end
  end

  assign ub_ad_o = rdata_q;
  assign ub_ad_oe_o = rd_act_q;

  // sticky flags: hardware set wins over the read clear
  always_comb begin
    sticky_set = 6'h00;
    sticky_set[IF_HEC] = ev_pulse[EV_HEC];                  // see R11
    sticky_set[IF_SHORT] = ev_pulse[EV_SHORT];              // see R12
    sticky_set[IF_PAR] = ev_pulse[EV_PAR];                  // see R5
    sticky_set[IF_CHG] = pin_s2_q[0] ^ pin_s3_q[0];         // see R13
    sticky_set[IF_SYM] = ev_pulse[EV_SYM];                  // see R14
    sticky_set[IF_OVR] = ev_pulse[EV_OVR];                  // see R15
    sticky_clr = (rd_stop && addr_q == OFF_FLAGS) ? 6'h3F : 6'h00; // see R16
    sticky_d = (sticky_q & ~sticky_clr) | sticky_set;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sticky_q <= STICKY_RST;
    end else begin
      sticky_q <= sticky_d;
    end
  end

  // control registers; the flush bit is cleared by hardware
  always_comb begin
    mc_d = mc_q;
    dc_d = dc_q;
    if (wr_commit && addr_q == OFF_MASTER) mc_d = wdata_q;
    if (wr_commit && addr_q == OFF_DIAG) begin
      dc_d = wdata_q;
      dc_d[DC_FLUSH] = wdata_q[DC_FLUSH] | dc_q[DC_FLUSH];
    end
    if (flush_done) dc_d[DC_FLUSH] = 1'b0;                  // see R20
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mc_q <= MASTER_RST;
      dc_q <= DIAG_RST;
    end else begin
      mc_q <= mc_d;
      dc_q <= dc_d;
    end
  end

  // flush handshake with the link domain, four phase
  always_comb begin
    fl_d = fl_q;
    flush_done = 1'b0;
    unique case (fl_q)
      FL_IDLE: if (dc_q[DC_FLUSH]) fl_d = FL_REQ;
      FL_REQ: begin
        if (ack_s2_q) begin
          fl_d = FL_DONE;
          flush_done = 1'b1;
        end
      end
      FL_DONE: if (!ack_s2_q) fl_d = FL_IDLE;
    endcase
    flreq_d = fl_d == FL_REQ;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fl_q <= FL_IDLE;
      flreq_q <= 1'b0;
    end else begin
      fl_q <= fl_d;
      flreq_q <= flreq_d;
    end
  end

  // interrupt pin, user pin, mode and loopback outputs
  assign loop_mode = atr_loop_decode(dc_q[1:0]);            // see R23, R26
  always_comb begin
    err_any = sticky_q[IF_HEC] | sticky_q[IF_SHORT] | sticky_q[IF_SYM];
    pend = mc_q[MC_ERR_ONLY] ? err_any : |sticky_q;         // see R3
    int_d = ~(mc_q[MC_INT_EN] & pend);                      // see R9, R25
    uol_d = ~mc_q[MC_UOL];                                  // see R1
    bym_d = mc_q[MC_BYTE];                                  // see R8
    phyl_d = loop_mode == LOOP_PHY;                         // see R24
    linl_d = loop_mode == LOOP_LINE;
    ctrl_d = '0;
    ctrl_d[CT_ERR_DISC] = mc_q[MC_ERR_DISC];
    ctrl_d[CT_IDLE_DISC] = mc_q[MC_IDLE_DISC];
    ctrl_d[CT_TXPAR] = mc_q[MC_TXPAR];
    ctrl_d[CT_HALT] = mc_q[MC_HALT];
    ctrl_d[CT_BYTE] = mc_q[MC_BYTE];
    ctrl_d[CT_FORCE] = dc_q[DC_FORCE];
    ctrl_d[CT_EARLY] = dc_q[DC_EARLY];
    ctrl_d[CT_MULTI] = dc_q[DC_MULTI];
    ctrl_d[CT_PAY_ERR] = dc_q[DC_PAY_ERR];
    ctrl_d[CT_HEC_ERR] = dc_q[DC_HEC_ERR];
    ctrl_d[CT_FLUSH] = flreq_q;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      int_q <= 1'b1;
      uol_q <= 1'b1;
      bym_q <= 1'b0;
      phyl_q <= 1'b0;
      linl_q <= 1'b0;
      ctrl_q <= '0;
    end else begin
      int_q <= int_d;
      uol_q <= uol_d;
      bym_q <= bym_d;
      phyl_q <= phyl_d;
      linl_q <= linl_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign int_n_o = int_q;
  assign user_out_pin_o = uol_q;
  assign utopia_byte_mode_o = bym_q;
  assign phy_loopback_o = phyl_q;
  assign line_loopback_o = linl_q;

  // link-clock logic: cell events, UTOPIA handshakes, tx byte path
  atr_link u_link (
    .link_clk_i(link_clk_i),
    .resetn_i(resetn_i),
    .ctrl_i(ctrl_q),
    .ev_tgl_o(ev_tgl),
    .flush_ack_o(flush_ack),
    .rx_cell_done_i(rx_cell_done_i),
    .rx_cell_short_i(rx_cell_short_i),
    .rx_cell_sym_err_i(rx_cell_sym_err_i),
    .rx_cell_hec_err_i(rx_cell_hec_err_i),
    .rx_cell_idle_i(rx_cell_idle_i),
    .rx_overrun_i(rx_overrun_i),
    .rx_cell_drop_o(rx_cell_drop_o),
    .rx_fifo_flush_o(rx_fifo_flush_o),
    .tx_byte_valid_i(tx_byte_valid_i),
    .tx_soc_i(tx_soc_i),
    .tx_data_i(tx_data_i),
    .tx_parity_i(tx_parity_i),
    .tx_clav_raw_i(tx_clav_raw_i),
    .txd_p_raw_i(txd_p_raw_i),
    .txd_n_raw_i(txd_n_raw_i),
    .tx_line_data_o(tx_line_data_o),
    .tx_line_valid_o(tx_line_valid_o),
    .tx_clav_o(tx_clav_o),
    .txd_p_o(txd_p_o),
    .txd_n_o(txd_n_o),
    .rx_enb_n_i(rx_enb_n_i),
    .rx_cells_queued_i(rx_cells_queued_i),
    .rx_byte_avail_i(rx_byte_avail_i),
    .rx_fifo_data_i(rx_fifo_data_i),
    .rx_fifo_parity_i(rx_fifo_parity_i),
    .rx_fifo_soc_i(rx_fifo_soc_i),
    .rx_data_o(rx_data_o),
    .receive_parity_out_o(receive_parity_out_o),
    .rx_soc_o(rx_soc_o),
    .rx_out_oe_o(rx_out_oe_o),
    .rx_clav_o(rx_clav_o),
    .rx_fifo_pop_o(rx_fifo_pop_o)
  );

  // checks on the register side
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  user_pin_a: assert property (wr_commit && addr_q == OFF_MASTER // see R1
    |=> ##1 user_out_pin_o == !$past(wdata_q[MC_UOL], 2))
    else $error("user pin not inverse of written latch bit");
  int_off_a: assert property (!mc_q[MC_INT_EN] |=> int_n_o) // see R9
    else $error("interrupt pin low while disabled");
  int_err_only_a: assert property (mc_q[MC_ERR_ONLY] && !err_any // see R3
    |=> int_n_o)
    else $error("non-cell-error flag raised interrupt");
  int_hold_a: assert property (mc_q[MC_INT_EN] && !mc_q[MC_ERR_ONLY] // see R25
    && (|sticky_q) |=> !int_n_o)
    else $error("interrupt not asserted for pending flag");
  flag_clear_a: assert property (rd_stop && addr_q == OFF_FLAGS // see R16
    && sticky_set == 6'h00 |=> sticky_q == 6'h00)
    else $error("flags not cleared after read");
  hec_set_a: assert property (ev_pulse[EV_HEC] // see R11
    |=> sticky_q[IF_HEC])
    else $error("hec event lost");
  sig_change_a: assert property (pin_s2_q[0] != pin_s3_q[0] // see R13
    |=> sticky_q[IF_CHG])
    else $error("signal change not flagged");
  flush_end_a: assert property ($rose(dc_q[DC_FLUSH]) && fl_q == FL_IDLE // see R20
    |=> ##[1:40] !dc_q[DC_FLUSH])
    else $error("flush bit not cleared by hardware");
  loop_rsvd_a: assert property (dc_q[1:0] == 2'b01 // see R26
    |=> !phy_loopback_o && !line_loopback_o)
    else $error("reserved loopback code left normal mode");

  flush_c: cover property (flush_done);
  int_c: cover property ($fell(int_n_o));
  read_clear_c: cover property (rd_stop && addr_q == OFF_FLAGS
    && sticky_q != 6'h00);
endmodule

// >>> atr_atm_model.sv
`timescale 1ns/1ps
// upstream cell source on the transmit side of the link
module atr_atm_model (
  input wire logic link_clk_i,
  output logic tx_byte_valid_o,
  output logic tx_soc_o,
  output logic [7:0] tx_data_o,
  output logic tx_parity_o
);
  // quiet bus from time zero
  initial begin
    tx_byte_valid_o = 1'b0;
    tx_soc_o = 1'b0;
    tx_data_o = 8'h00;
    tx_parity_o = 1'b0;
  end
  // one whole cell, data values counting from one; the byte at index bad, counted from zero, gets even parity
  task send_cell(input logic [7:0] bad);
    for (int i = 0; i < 53; i++) begin
      @(negedge link_clk_i);
      tx_byte_valid_o = 1'b1;
      tx_soc_o = (i == 0);
      tx_data_o = 8'(i + 1);
      tx_parity_o = ~^tx_data_o ^ (i == bad);
    end
    @(negedge link_clk_i);
    tx_byte_valid_o = 1'b0;
    tx_soc_o = 1'b0;
    tx_data_o = ~tx_data_o; // released data must not look held
  endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
  err_count++; $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module tb_top import atr_pkg::*;;
  logic core_clk_i = 0, link_clk_i = 0, resetn_i = 0;
  logic ub_cs_n_i = 1, ub_ale_i = 0, ub_rd_n_i = 1, ub_wr_n_i = 1;
  logic [7:0] ad_drv = 0, ub_ad_o, rx_data_o, tx_line_data_o, rv;
  logic ub_ad_oe_o, user_out_pin_o, int_n_o, utopia_byte_mode_o;
  logic phy_loopback_o, line_loopback_o, rx_cell_drop_o, tx_clav_o;
  logic tx_line_valid_o, txd_p_o, txd_n_o, rx_out_oe_o, rx_soc_o, rx_clav_o;
  logic rx_fifo_flush_o, receive_parity_out_o, rx_fifo_pop_o;
  logic rx_signal_good_i = 0, rx_cell_done_i = 0, rx_cell_short_i = 0;
  logic rx_cell_sym_err_i = 0, rx_cell_hec_err_i = 0, rx_cell_idle_i = 0;
  logic rx_overrun_i = 0, tx_clav_raw_i = 1, rx_enb_n_i = 1;
  logic txd_p_raw_i = 1, txd_n_raw_i = 1;
  logic tx_byte_valid_i, tx_soc_i, tx_parity_i;
  logic [7:0] tx_data_i;
  logic [1:0] rx_cells_queued_i = 0;
  logic rx_byte_avail_i = 0, rx_fifo_parity_i = 0, rx_fifo_soc_i = 0;
  logic [7:0] rx_fifo_data_i = 8'h00;
  logic [7:0] cap [0:52];
  int err_count = 0, total_checks = 0, tx_cnt = 0, fl_cnt = 0;
  // shared address/data wire: device wins while it drives
  wire logic [7:0] ub_ad_i = ub_ad_oe_o ? ub_ad_o : ad_drv;

  always #25 core_clk_i = ~core_clk_i;
  // link clock, unrelated phase
  initial begin
    #11;
    forever #32 link_clk_i = ~link_clk_i;
  end

  atr_regs atr_regs_i (.core_clk_i, .link_clk_i, .resetn_i, .ub_cs_n_i,
    .ub_ale_i, .ub_rd_n_i, .ub_wr_n_i, .ub_ad_i, .ub_ad_o, .ub_ad_oe_o,
    .rx_signal_good_i, .user_out_pin_o, .int_n_o, .utopia_byte_mode_o,
    .phy_loopback_o, .line_loopback_o, .rx_cell_done_i, .rx_cell_short_i,
    .rx_cell_sym_err_i, .rx_cell_hec_err_i, .rx_cell_idle_i, .rx_overrun_i,
    .rx_cell_drop_o, .rx_fifo_flush_o, .tx_byte_valid_i, .tx_soc_i,
    .tx_data_i, .tx_parity_i, .tx_clav_raw_i, .txd_p_raw_i, .txd_n_raw_i,
    .tx_line_data_o, .tx_line_valid_o, .tx_clav_o, .txd_p_o, .txd_n_o,
    .rx_enb_n_i, .rx_cells_queued_i, .rx_byte_avail_i, .rx_fifo_data_i,
    .rx_fifo_parity_i, .rx_fifo_soc_i, .rx_data_o,
    .receive_parity_out_o, .rx_soc_o, .rx_out_oe_o, .rx_clav_o,
    .rx_fifo_pop_o);

  atr_atm_model atr_atm_model_i (.link_clk_i, .tx_byte_valid_o(tx_byte_valid_i),
    .tx_soc_o(tx_soc_i), .tx_data_o(tx_data_i), .tx_parity_o(tx_parity_i));

  // capture line bytes in order
  always @(posedge link_clk_i) begin
    if (tx_line_valid_o === 1'b1 && tx_cnt < 53) begin
      cap[tx_cnt] <= tx_line_data_o;
      tx_cnt <= tx_cnt + 1;
    end
    if (rx_fifo_flush_o === 1'b1) fl_cnt <= fl_cnt + 1;
  end

  task summarize;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one utility bus cycle: address phase, then write or read strobe
  task bus(input logic [7:0] a, input logic wr, input logic [7:0] d);
    int n;
    @(negedge core_clk_i);
    ub_cs_n_i = 0;
    ad_drv = a;
    ub_ale_i = 1;
    repeat (5) @(negedge core_clk_i);
    ub_ale_i = 0;
    repeat (5) @(negedge core_clk_i);
    if (wr) begin
      ad_drv = d;
      ub_wr_n_i = 0;
      repeat (6) @(negedge core_clk_i);
      ub_wr_n_i = 1;
    end else begin
      ad_drv = ~a;
      ub_rd_n_i = 0;
      n = 0;
      while (ub_ad_oe_o !== 1'b1 && n < 20) begin
        @(negedge core_clk_i);
        n++;
      end
      if (n == 20) begin
        err_count++;
        summarize();
      end
      rv = ub_ad_i;
      repeat (2) @(negedge core_clk_i);
      ub_rd_n_i = 1;
    end
    repeat (8) @(negedge core_clk_i);
    ub_cs_n_i = 1;
    ad_drv = ~ad_drv;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask

  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    `CHK($sformatf("reg %0h", a), e, rv)
  endtask

  // one receive event with qualifiers {ovr, idle, hec, sym, short}; cell end only when idle, hec, sym or short is set
  task ev(input logic [4:0] q, input logic drop);
    @(negedge link_clk_i);
    {rx_overrun_i, rx_cell_idle_i, rx_cell_hec_err_i, rx_cell_sym_err_i,
      rx_cell_short_i} = q;
    rx_cell_done_i = |q[3:0];
    #1 `CHK("drop", drop, rx_cell_drop_o)
    @(negedge link_clk_i);
    {rx_overrun_i, rx_cell_idle_i, rx_cell_hec_err_i, rx_cell_sym_err_i,
      rx_cell_short_i} = 5'h00;
    rx_cell_done_i = 0;
    repeat (20) @(negedge core_clk_i);
  endtask

  // main sequence
  initial begin
    repeat (16) @(negedge core_clk_i);
    resetn_i = 1;
    repeat (4) @(negedge core_clk_i);
    `CHK("pin", 1'b1, user_out_pin_o)
    rd_chk(OFF_MASTER, MASTER_RST);
    rd_chk(OFF_FLAGS, 8'h00);
    rd_chk(OFF_DIAG, 8'h00);
    rd_chk(8'h05, 8'h00);
    wr(OFF_MASTER, 8'hDB);
    rd_chk(OFF_MASTER, 8'hDB);
    `CHK("pin", 1'b0, user_out_pin_o)
    `CHK("mode", 1'b1, utopia_byte_mode_o)
    wr(OFF_DIAG, 8'h0C);
    tx_cnt = 0;
    atr_atm_model_i.send_cell(8'd3);
    repeat (20) @(negedge core_clk_i);
    `CHK("hec byte", 8'h04, cap[4])
    `CHK("last byte", 8'h34, cap[52])
    `CHK("int", 1'b0, int_n_o)
    rd_chk(OFF_FLAGS, 8'h08);
    rd_chk(OFF_FLAGS, 8'h00);
    `CHK("int", 1'b1, int_n_o)
    for (int k = 0; k < 5; k++) ev(5'h01 << k, k < 4);
    rd_chk(OFF_FLAGS, 8'h33);
    wr(OFF_MASTER, 8'h21);
    rx_signal_good_i = 1;
    repeat (20) @(negedge core_clk_i);
    `CHK("int", 1'b1, int_n_o)
    rd_chk(OFF_FLAGS, 8'h44);
    ev(5'h02, 1'b0);
    `CHK("int", 1'b0, int_n_o)
    rd_chk(OFF_FLAGS, 8'h42);
    wr(OFF_MASTER, 8'h04);
    `CHK("txd", 2'b00, {txd_p_o, txd_n_o})
    `CHK("mode", 1'b0, utopia_byte_mode_o)
    ev(5'h0C, 1'b0);
    `CHK("int", 1'b1, int_n_o)
    wr(OFF_DIAG, 8'hA2);
    `CHK("clav", 1'b0, tx_clav_o)
    `CHK("rx oe", 1'b0, rx_out_oe_o)
    for (int c = 0; c < 4; c++) begin
      wr(OFF_DIAG, 8'(c));
      `CHK("loop", {c == 3, c == 2}, {line_loopback_o, phy_loopback_o})
    end
    `CHK("rx oe", 1'b1, rx_out_oe_o)
    `CHK("clav", 1'b1, tx_clav_o)
    // receive side: early clav in cell mode, then byte mode clav
    wr(OFF_DIAG, 8'h40);
    @(negedge link_clk_i);
    {rx_cells_queued_i, rx_byte_avail_i, rx_fifo_soc_i, rx_enb_n_i} = 5'h0E;
    {rx_fifo_data_i, rx_fifo_parity_i} = 9'h14B;
    @(negedge link_clk_i);
    rx_fifo_soc_i = 0;
    `CHK("rx data", 8'hA5, rx_data_o)
    `CHK("rx flags", 2'b11, {receive_parity_out_o, rx_soc_o})
    `CHK("rx pop", 1'b1, rx_fifo_pop_o)
    repeat (47) @(negedge link_clk_i);
    `CHK("rx clav", 1'b1, rx_clav_o)
    @(negedge link_clk_i);
    `CHK("rx clav", 1'b0, rx_clav_o)
    rx_cells_queued_i = 0;
    wr(OFF_MASTER, 8'h06);
    `CHK("rx clav", 1'b1, rx_clav_o)
    wr(OFF_DIAG, 8'h10);
    repeat (50) @(negedge core_clk_i);
    rd_chk(OFF_DIAG, 8'h00);
    `CHK("flush", 1, fl_cnt)
    summarize();
  end
endmodule
